// >>> shared/spi_mon_pkg.sv
// package: constants for the switch monitor serial slave port
package spi_mon_pkg;
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned CNT_W        = 6;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned DATA_W       = 24;
  localparam int unsigned FLAG_W       = 4;
  // command frame field positions
  localparam int unsigned RW_POS       = 31;
  localparam int unsigned ADDR_MSB     = 30;
  localparam int unsigned ADDR_LSB     = 25;
  localparam int unsigned DATA_MSB     = 24;
  localparam int unsigned DATA_LSB     = 1;
  // bits received when the address is complete
  localparam logic [5:0]  ADDR_DONE    = 6'h07;
  // interrupt status flag positions
  localparam int unsigned FLG_RESET    = 3;
  localparam int unsigned FLG_LEN      = 2;
  localparam int unsigned FLG_PAR      = 1;
  localparam int unsigned FLG_SSC      = 0;
  // serial clock limit (host side), in kHz
  localparam int unsigned SCLK_MAX_KHZ = 4000;
  localparam logic [31:0] RESET_FRAME  = 32'h0000_0000;
endpackage : spi_mon_pkg

// >>> src/switch_monitor_spi_slave.sv
// module: serial slave port of the switch monitor, sampled on the system clock
`timescale 1ns/1ps

module switch_monitor_spi_slave
  import spi_mon_pkg::*;
#(
  parameter logic [5:0] STATUS_ADDR = 6'h01  // address of the interrupt status register
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              clk_en,
  input  wire logic                              cs_n,
  input  wire logic                              sclk,
  input  wire logic                              si,
  output logic                                   so_o,
  output logic                                   so_oe,
  output logic                                   int_n,
  input  wire logic [spi_mon_pkg::FLAG_W-1:0]    int_stat,
  input  wire logic                              int_pending,
  output logic                                   len_err_set,
  output logic                                   par_err_set,
  output logic                                   int_stat_clr,
  output logic [spi_mon_pkg::ADDR_W-1:0]         reg_addr,
  input  wire logic [spi_mon_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic                              reg_valid,
  input  wire logic                              reg_writable,
  output logic                                   reg_wr,
  output logic [spi_mon_pkg::DATA_W-1:0]         reg_wdata
);
  import spi_mon_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0]          cs_s;
    logic [2:0]          sck_s;
    logic [2:0]          si_s;
    logic                active;
    logic [CNT_W-1:0]    cnt;
    logic [31:0]         rx;
    logic [31:0]         tx;
    logic                load;
    logic                so;
    logic                oe;
    logic [FLAG_W-1:0]   flags;
    logic                int_lo;
    logic                len_set;
    logic                par_set;
    logic                clr;
    logic                wr;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } state_s;

  state_s st_q;
  state_s st_d;

  // odd parity over 31 bits: the parity bit makes the total count odd
  function automatic logic par_bit(input logic [30:0] v);
    par_bit = ~(^v);
  endfunction : par_bit

  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic sck_rise;
  logic [31:0] rx_next;
  logic [31:0] reply;

  // ==========================================================
  // edge detection where the second and third stages differ
  assign cs_fall  = st_q.cs_s[2] & ~st_q.cs_s[1];
  assign cs_rise  = ~st_q.cs_s[2] & st_q.cs_s[1];
  assign sck_fall = st_q.active & st_q.sck_s[2] & ~st_q.sck_s[1];
  assign sck_rise = st_q.active & ~st_q.sck_s[2] & st_q.sck_s[1];
  assign rx_next  = {st_q.rx[30:0], st_q.si_s[2]};

  // reply frame: flags, then data (zeros if unassigned), then parity
  always_comb begin
    reply = RESET_FRAME;
    if (reg_valid) begin
      reply[30:31-FLAG_W] = st_q.flags;
      reply[DATA_MSB:DATA_LSB] = reg_rdata;
      reply[0] = par_bit(reply[31:1]);
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.cs_s  = {st_q.cs_s[1:0], cs_n};
    st_d.sck_s = {st_q.sck_s[1:0], sclk};
    st_d.si_s  = {st_q.si_s[1:0], si};
    st_d.len_set = 1'b0;
    st_d.par_set = 1'b0;
    st_d.clr = 1'b0;
    st_d.wr  = 1'b0;
    st_d.load = 1'b0;
    if (int_pending) begin
      st_d.int_lo = 1'b1;  // a new event wins over a release
    end
    if (cs_fall) begin
      st_d.active = 1'b1;
      st_d.oe     = 1'b1;
      st_d.so     = 1'b1;
      st_d.flags  = int_stat;
      st_d.cnt    = '0;
      st_d.tx     = RESET_FRAME;
    end else if (cs_rise && st_q.active) begin
      st_d.active = 1'b0;
      st_d.oe     = 1'b0;
      if (st_q.cnt != CNT_W'(FRAME_BITS) && st_q.cnt != '0) begin
        st_d.len_set = 1'b1;
        st_d.int_lo  = 1'b1;
      end else if (st_q.cnt != '0 && ~(^st_q.rx)) begin
        st_d.par_set = 1'b1;
        st_d.int_lo  = 1'b1;
      end else if (st_q.cnt != '0) begin
        if (st_q.rx[RW_POS] && reg_valid && reg_writable) begin
          st_d.wr    = 1'b1;
          st_d.wdata = st_q.rx[DATA_MSB:DATA_LSB];
        end else if (!st_q.rx[RW_POS] && st_q.addr == STATUS_ADDR) begin
          st_d.clr = 1'b1;
          if (!int_pending) begin
            st_d.int_lo = 1'b0;
          end
        end
      end
    end else if (st_q.active) begin
      // the addressed register's contents replace the tail once the address is in;
      // the flags have already left, so an unassigned address zeroes data and parity only
      if (st_q.load) begin
        st_d.tx = {reply[DATA_MSB:0], 7'h00};
      end
      if (sck_rise) begin
        if (st_q.cnt == '0) begin
          st_d.so = 1'b0;                                          // reply bit 31 is always zero
          st_d.tx = {st_q.flags, 28'h000_0000};
        end else begin
          st_d.so = st_q.tx[31];
          st_d.tx = {st_q.tx[30:0], 1'b0};
        end
      end
      if (sck_fall) begin
        st_d.rx = rx_next;
        if (st_q.cnt != {CNT_W{1'b1}}) begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
        if (st_q.cnt + 1'b1 == ADDR_DONE) begin
          st_d.addr = rx_next[ADDR_W-1:0];
          st_d.load = 1'b1;                                        // reload one cycle later, well before the next rise
        end
      end
    end
  end

  // ==========================================================
  // registers; clk_en low freezes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.cs_s <= 3'b111;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign so_o         = st_q.so;
  assign so_oe        = st_q.oe;
  assign int_n        = ~st_q.int_lo;
  assign len_err_set  = st_q.len_set;
  assign par_err_set  = st_q.par_set;
  assign int_stat_clr = st_q.clr;
  assign reg_addr     = st_q.addr;
  assign reg_wr       = st_q.wr;
  assign reg_wdata    = st_q.wdata;

  // ==========================================================
  // checks
  a_oe_after_fall: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cs_fall |=> so_oe && so_o) else $error("output not driven high after select fall");
  a_oe_off_rise: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cs_rise && st_q.active |=> !so_oe) else $error("output still driven after select rise");
  a_release_int: assert property (@(posedge clk) disable iff (!rst_n)
    int_stat_clr && !$past(int_pending) |-> int_n) else $error("interrupt not released on status read");
  a_idle_float: assert property (@(posedge clk) disable iff (!rst_n)
    !st_q.active |-> !so_oe) else $error("output driven while deselected");
  a_len_err: assert property (@(posedge clk) disable iff (!rst_n)
    len_err_set |-> !int_n && !reg_wr) else $error("length error without interrupt");
  a_no_clk_err: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cs_rise && st_q.cnt == '0 |=> !len_err_set) else $error("length error on empty frame");
  a_par_err: assert property (@(posedge clk) disable iff (!rst_n)
    par_err_set |-> !int_n && !reg_wr) else $error("parity error without interrupt");
  a_write_gate: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr |-> $past(reg_writable) && $past(st_q.cnt) == 6'd32) else $error("bad write committed");
  a_rise_shift: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sck_rise && st_q.cnt != '0 && !cs_rise |=> so_o == $past(st_q.tx[31])) else $error("shift out wrong");
  a_pending_low: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && int_pending |=> !int_n) else $error("interrupt not held low by pending event");
endmodule : switch_monitor_spi_slave

// >>> verif/spi_host_model.sv
// host model: bit-bangs command frames with a 160 ns serial clock
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk,
  input  wire logic so_o,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  logic last_q = 1'b0;
  // a released output shows the inverse of its last level, never a stale bit
  wire  so_w   = so_oe ? so_o : ~last_q;
  always @(posedge clk) begin
    if (so_oe) last_q <= so_o;
  end
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // rx[32] holds the level seen before the first rising edge
  task automatic frame(input logic [31:0] cmd, input int n, output logic [32:0] rx);
    repeat (2) @(negedge clk);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
    rx = {so_w, 32'h0000_0000};
    for (int i = 0; i < n; i++) begin
      si = cmd[(31 - i) & 31];
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      repeat (8) @(negedge clk);
      rx[31:0] = {rx[30:0], so_w};
      sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
  endtask : frame
  // wiggle clock and data while deselected; ends with the clock low
  task automatic noise();
    for (int i = 0; i < 6; i++) begin
      repeat (3) @(negedge clk);
      sclk = ~sclk;
      si = ~si;
    end
  endtask : noise
endmodule : spi_host_model

// >>> verif/tb_switch_monitor_spi_slave.sv
// testbench: host model sends frames, a monitor checks the port pulses
`timescale 1ns/1ps
module tb_switch_monitor_spi_slave;
  import spi_mon_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, sclk, si, so_o, so_oe, int_n, len_err_set, par_err_set, int_stat_clr, reg_wr;
  logic [3:0]  int_stat = 4'h0;
  logic        int_pending = 1'b0;
  logic [5:0]  reg_addr;
  wire         reg_valid_w = (reg_addr[5:4] != 2'b11);  // top quarter of the address map is unassigned
  logic [23:0] reg_wdata;
  logic [27:0] exp_q[$];
  logic [31:0] seed = 32'h0000_002b;
  logic [32:0] rx;
  int          fails = 0;
  int          tests_run = 0;
  always #5 clk = ~clk;
  // =====================================
  // design and host
  switch_monitor_spi_slave i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so_o(so_o), .so_oe(so_oe), .int_n(int_n), .int_stat(int_stat), .int_pending(int_pending),
    .len_err_set(len_err_set), .par_err_set(par_err_set), .int_stat_clr(int_stat_clr), .reg_addr(reg_addr),
    .reg_rdata({4{reg_addr}}), .reg_valid(reg_valid_w), .reg_writable(~reg_addr[5]), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  spi_host_model i_host (.clk(clk), .so_o(so_o), .so_oe(so_oe), .cs_n(cs_n), .sclk(sclk), .si(si));
  // =====================================
  // checking
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // each pulse consumes the oldest note; looked at on the falling edge, away from its launch
  always @(negedge clk) begin
    if (len_err_set | par_err_set | int_stat_clr | reg_wr) begin
      if (exp_q.size() == 0) check("extra pulse", 32'h1, 32'h0);
      else check("pulse", {len_err_set, par_err_set, int_stat_clr, reg_wr, reg_wr ? reg_wdata : 24'h0}, exp_q.pop_front());
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // one frame of n bits; reply data comes from the address sent in this frame
  task automatic xfer(input logic rw, input logic [5:0] a, input int n, input logic bad);
    logic [31:0] cmd, rep;
    seed = lfsr(seed);
    int_stat = seed[7:4];
    cmd = {rw, a, seed[31:8], 1'b0};
    cmd[0] = ~^cmd[31:1] ^ bad;
    rep = {1'b0, int_stat, 2'b00, {4{a}}, 1'b0};
    rep[0] = ~^rep[31:1];
    if (a[5:4] == 2'b11) rep[24:0] = 25'h0; // flags leave before the address is known
    if (n != 32) begin
      if (n != 0) exp_q.push_back(28'h800_0000);
    end else if (bad) exp_q.push_back(28'h400_0000);
    else if (rw && !a[5]) exp_q.push_back({4'b0001, cmd[24:1]});
    else if (!rw && a == 6'h01) exp_q.push_back(28'h200_0000);
    i_host.frame(cmd, n, rx);
    if (n == 32) check("reply", rx[31:0], rep);
    check("first level", {31'h0, rx[32]}, 32'h1);
    repeat (6) @(negedge clk);
    check("driver off", {31'h0, so_oe}, 32'h0);
  endtask : xfer
  // =====================================
  // scenarios
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    xfer(1'b1, 6'h02, 32, 1'b0);
    xfer(1'b1, 6'h02, 32, 1'b0);
    xfer(1'b1, 6'h22, 32, 1'b0);
    i_host.noise();
    xfer(1'b0, 6'h05, 0, 1'b0);
    xfer(1'b0, 6'h05, 31, 1'b0);
    check("int low", {31'h0, int_n}, 32'h0);
    xfer(1'b0, 6'h05, 33, 1'b0);
    xfer(1'b1, 6'h03, 32, 1'b1);
    xfer(1'b0, 6'h01, 32, 1'b0);
    check("int high", {31'h0, int_n}, 32'h1);
    xfer(1'b0, 6'h22, 32, 1'b0);
    xfer(1'b0, 6'h35, 32, 1'b0);
    int_pending = 1'b1;
    xfer(1'b0, 6'h01, 32, 1'b0);
    check("int held", {31'h0, int_n}, 32'h0);
    int_pending = 1'b0;
    xfer(1'b0, 6'h01, 32, 1'b0);
    check("int released", {31'h0, int_n}, 32'h1);
    repeat (10) @(negedge clk);
    check("left over", exp_q.size(), 32'h0);
    finish_test();
  end
  // about five times the expected run
  initial begin
    #300000;
    fails++;
    finish_test();
  end
endmodule : tb_switch_monitor_spi_slave
